// File: hw/dpo_phase_offset_ctrl.sv
// Purpose: programmable output phase offset with ramping, and time bias reg
// Assumes: register writes are one-cycle strobes in the clk domain
// Notes: lower offset byte is held elsewhere and arrives on offset_low
//
// Notes on behaviour
// - high and low bytes join into one signed 16-bit two's complement offset
// - one offset step is the internal period over two to the eleventh
// - a value of 1024 shifts half a period, inverting the output clock
// - while locked, a new offset is reached gradually, at most STEP_MAX steps per update
// - a supervision bit disables ramping; meant for holdover-only changes
// - while build-out is enabled the programmed offset has no effect
// - build-out time bias register; its top two bits are unused
`timescale 1ns/100ps
module dpo_phase_offset_ctrl
   import dpo_pkg::*;
#(
   parameter int UPDATE_CYCLES = DPO_UPDATE_CYCLES,
   parameter int STEP_MAX = DPO_STEP_MAX
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // high offset byte register port
   input wire logic high_wr,
   input wire logic [7:0] high_wdata,
   output logic [7:0] high_rdata,
   // lower offset byte, held in its own register
   input wire logic [7:0] offset_low,
   // build-out time bias register port
   input wire logic bias_wr,
   input wire logic [7:0] bias_wdata,
   output logic [7:0] bias_rdata,
   // pll state and supervision controls
   input wire dpo_cfg_type cfg,
   // applied phase shift
   output logic signed [15:0] applied_offset,
   output logic ramp_busy,
   output logic output_inverted,
   output logic [5:0] bias_field
);
   logic [7:0] high_reg, high_next;
   logic [DPO_BIAS_FIELD_W-1:0] bias_reg, bias_next;
   logic signed [15:0] applied_reg, applied_next;
   logic [DPO_TIMER_W-1:0] timer_reg, timer_next;
   dpo_state_type state_reg, state_next;
   logic signed [15:0] target;
   logic signed [15:0] effective;
   logic signed [15:0] stepped;
   logic tick;
   logic ramp_on;
   localparam logic [DPO_TIMER_W-1:0] TIMER_LOAD =
      DPO_TIMER_W'(UPDATE_CYCLES - 1);

   assign target = {high_reg, offset_low};
   // build-out owns the phase, so the programmed offset is dropped
   assign effective = cfg.buildout_en ? 16'sh0000 : target;
   // update strobe, once every UPDATE_CYCLES clocks
   assign tick = (timer_reg == '0);
   // only ramp while locked; free-run and holdover may step at once
   assign ramp_on = cfg.locked && !cfg.ramp_disable;

   dpo_ramp_step #(
      .STEP_MAX(STEP_MAX)
   ) u_step (
      .cur(applied_reg),
      .tgt(effective),
      .nxt(stepped)
   );

   // register writes; bias keeps only its six used bits
   always_comb
   begin
      high_next = high_wr ? high_wdata : high_reg;
      bias_next = bias_wr ? bias_wdata[DPO_BIAS_FIELD_W-1:0] : bias_reg;
   end

   // update interval timer and applied offset; a target that moves mid ramp
   // just redirects it, since each step is taken against the live target,
   // and a dropped lock hands over to a direct step at once
   always_comb
   begin
      timer_next = tick ? TIMER_LOAD : timer_reg - 1'b1;
      applied_next = applied_reg;
      state_next = state_reg;
      case (state_reg)
         DPO_SETTLED:
         begin
            if (applied_reg != effective)
            begin
               if (ramp_on)
                  state_next = DPO_RAMPING;
               else
                  applied_next = effective;
            end
         end
         DPO_RAMPING:
         begin
            if (!ramp_on)
            begin
               applied_next = effective;
               state_next = DPO_SETTLED;
            end
            else if (tick)
            begin
               applied_next = stepped;
               if (stepped == effective)
                  state_next = DPO_SETTLED;
            end
         end
         default:
         begin
            state_next = DPO_SETTLED;
         end
      endcase
   end

   // register file; kept apart from the ramp so that a ramp in progress
   // never disturbs what software reads back
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         high_reg <= DPO_HIGH_RESET;
         bias_reg <= DPO_BIAS_RESET[DPO_BIAS_FIELD_W-1:0];
      end
      else
      begin
         high_reg <= high_next;
         bias_reg <= bias_next;
      end
   end

   // ramp state; the timer free-runs so update ticks keep a fixed cadence
   // whatever the software does in between
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         applied_reg <= '0;
         timer_reg <= '0;
         state_reg <= DPO_SETTLED;
      end
      else
      begin
         applied_reg <= applied_next;
         timer_reg <= timer_next;
         state_reg <= state_next;
      end
   end

   // outputs; the low 11 bits are the fraction of one internal period
   assign high_rdata = high_reg;
   assign bias_rdata = {DPO_BIAS_UNUSED, bias_reg};
   assign bias_field = bias_reg;
   assign applied_offset = applied_reg;
   assign ramp_busy = (state_reg == DPO_RAMPING);
   assign output_inverted =
      (applied_reg[DPO_FRAC_BITS-1:0] == DPO_HALF_PERIOD);

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // register file checks
   high_write_a: assert property (high_wr |=> high_rdata == $past(high_wdata))
      else $error("high offset byte not stored");
   high_keep_a: assert property (!high_wr |=> $stable(high_rdata))
      else $error("high offset byte changed without a write");
   join_bytes_a: assert property (
      !cfg.buildout_en |-> effective == {high_rdata, offset_low})
      else $error("offset bytes not joined");
   // half of the two to the eleventh steps of one period is the inversion
   invert_flag_a: assert property (
      output_inverted == (applied_offset[DPO_FRAC_BITS-1:0] ==
      11'(2 ** (DPO_FRAC_BITS - 1))))
      else $error("inversion flag wrong");

   // ramp checks; the step difference is taken one bit wider than the
   // offset so that a wrap across the sign cannot hide a large jump
   ramp_bound_a: assert property (
      $past(ramp_on) && ramp_on && $past(rst_n)
      |-> 17'(applied_reg) - 17'($past(applied_reg)) <= 17'(STEP_MAX)
      && 17'(applied_reg) - 17'($past(applied_reg)) >= -17'(STEP_MAX))
      else $error("ramp step too large");
   ramp_tick_a: assert property (
      ramp_busy && ramp_on && !tick |=> $stable(applied_offset))
      else $error("offset moved between updates");
   busy_step_a: assert property (
      ramp_busy && ramp_on && tick && applied_offset != effective
      |=> applied_offset != $past(applied_offset))
      else $error("ramp did not advance on an update");
   settle_hold_a: assert property (
      !ramp_busy && ramp_on && applied_offset == effective
      |=> $stable(applied_offset))
      else $error("settled offset moved");
   busy_locked_a: assert property (ramp_busy |-> $past(ramp_on))
      else $error("ramp running while not locked");

   // build-out, bias, direct step and ramp start checks
   bias_store_a: assert property (
      bias_wr |=> bias_field == $past(bias_wdata[DPO_BIAS_FIELD_W-1:0]))
      else $error("bias field not stored");
   bias_keep_a: assert property (!bias_wr |=> $stable(bias_field))
      else $error("bias field changed without a write");
   no_ramp_a: assert property (
      !ramp_on && !ramp_busy |=> applied_offset == $past(effective))
      else $error("offset not stepped directly");
   buildout_zero_a: assert property (
      cfg.buildout_en && !ramp_on |=> applied_offset == 16'sh0000)
      else $error("offset applied during build-out");
   bias_unused_a: assert property (bias_rdata[7:6] == 2'h0)
      else $error("unused bias bits set");
   ramp_start_a: assert property (
      !ramp_busy && ramp_on && applied_offset != effective
      |=> ramp_busy ##0 $stable(applied_offset))
      else $error("locked offset change not ramped");
endmodule : dpo_phase_offset_ctrl

// File: hw/dpo_pkg.sv
// Purpose: shared constants and types for the output phase offset control
// Assumes: internal clock domain, registers reached through plain ports
// Notes: offset step is one internal period divided by two to the eleventh
package dpo_pkg;
   // register widths and reset values
   localparam int DPO_BYTE_W = 8;
   localparam int DPO_OFFSET_W = 16;
   localparam logic [7:0] DPO_HIGH_RESET = 8'h00;
   localparam logic [7:0] DPO_BIAS_RESET = 8'h00;
   // bias register: low six bits hold the field, top two unused
   localparam int DPO_BIAS_FIELD_W = 6;
   localparam logic [1:0] DPO_BIAS_UNUSED = 2'h0;
   // internal period in femtoseconds: 1e12 divided by the clock in kHz
   localparam longint DPO_INT_CLK_KHZ = 77760;
   localparam longint DPO_INT_PERIOD_FS = 64'd1000000000000 / DPO_INT_CLK_KHZ;
   localparam int DPO_FRAC_BITS = 11;
   // one offset step, about 6.279 ps
   localparam longint DPO_LSB_FS = DPO_INT_PERIOD_FS >> DPO_FRAC_BITS;
   // value giving half an internal period, i.e. full inversion
   localparam logic [10:0] DPO_HALF_PERIOD = 11'h400;
   // ramp update interval, counted on the 250 MHz block clock
   localparam int DPO_CLK_PERIOD_NS = 4;
   localparam int DPO_UPDATE_NS = 1000;
   localparam int DPO_UPDATE_CYCLES = DPO_UPDATE_NS / DPO_CLK_PERIOD_NS;
   localparam int DPO_STEP_MAX = 8;
   localparam int DPO_TIMER_W = 16;
   // control inputs that travel together
   typedef struct packed {
      logic locked;
      logic ramp_disable;
      logic buildout_en;
   } dpo_cfg_type;
   // ramp state, one-hot
   typedef enum logic [1:0] {
      DPO_SETTLED = 2'b01,
      DPO_RAMPING = 2'b10
   } dpo_state_type;
endpackage : dpo_pkg

// File: hw/dpo_ramp_step.sv
// Purpose: one bounded ramp step from the current toward the target offset
// Assumes: step_max is positive and below the offset range
// Notes: purely combinational
`timescale 1ns/100ps
module dpo_ramp_step
   import dpo_pkg::*;
#(
   parameter int STEP_MAX = DPO_STEP_MAX
)
(
   // offsets in
   input wire logic signed [15:0] cur,
   input wire logic signed [15:0] tgt,
   // offset out
   output logic signed [15:0] nxt
);
   logic signed [16:0] diff;
   localparam logic signed [16:0] STEP = 17'(STEP_MAX);

   // limit the move so internal dividers never lose alignment
   always_comb
   begin
      diff = 17'(tgt) - 17'(cur);
      if (diff > STEP)
         nxt = 16'(cur + 16'(STEP_MAX));
      else if (diff < -STEP)
         nxt = 16'(cur - 16'(STEP_MAX));
      else
         nxt = tgt;
   end
endmodule : dpo_ramp_step

// File: verification/dpo_testbench.sv
// Purpose: self-checking bench for the output phase offset control block
// Assumes: short update interval so that ramps finish quickly
// Notes: the driver queues expectations, a watcher compares them
`timescale 1ns/100ps
module testbench
   import dpo_pkg::*;
;
   typedef struct {int sel; logic [15:0] exp;} dpo_note_type;
   dpo_note_type notes[$];
   string names[6] = '{"applied", "high_rd", "bias_rd", "field", "inv",
      "busy"};
   event look;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   logic clk = 0, rst_n = 0, high_wr = 0, bias_wr = 0, watch = 0;
   logic [7:0] high_wdata = 8'h00, offset_low = 8'h00, bias_wdata = 8'h00;
   logic [7:0] high_rdata, bias_rdata, lo;
   logic [5:0] bias_field;
   logic signed [15:0] applied_offset, prev;
   logic ramp_busy, output_inverted;
   dpo_cfg_type cfg = '0;
   dpo_phase_offset_ctrl #(.UPDATE_CYCLES(4), .STEP_MAX(8))
      dpo_phase_offset_ctrl_inst (.clk(clk), .rst_n(rst_n),
      .high_wr(high_wr), .high_wdata(high_wdata), .high_rdata(high_rdata),
      .offset_low(offset_low), .bias_wr(bias_wr), .bias_wdata(bias_wdata),
      .bias_rdata(bias_rdata), .cfg(cfg), .applied_offset(applied_offset),
      .ramp_busy(ramp_busy), .output_inverted(output_inverted),
      .bias_field(bias_field));
   // 250 MHz clock
   initial
   begin
      forever #2 clk = ~clk;
   end
   // watcher: oldest note against the output it names
   always @(look)
   begin
      dpo_note_type n;
      logic [15:0] got;
      n = notes.pop_front();
      case (n.sel)
         0: got = applied_offset;
         1: got = {8'h00, high_rdata};
         2: got = {8'h00, bias_rdata};
         3: got = {10'h000, bias_field};
         4: got = {15'h0000, output_inverted};
         default: got = {15'h0000, ramp_busy};
      endcase
      total_checks++;
      if (got !== n.exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", names[n.sel], n.exp, got);
      end
   end
   // a ramp may move the applied offset only a few steps per update
   always @(posedge clk)
   begin
      #1;
      if (watch && (int'(applied_offset) - int'(prev) > 8 ||
         int'(prev) - int'(applied_offset) > 8))
      begin
         mismatches++;
         $display("mismatch step expected 8 seen %h", applied_offset - prev);
      end
      prev = applied_offset;
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         test_done();
      end
   end
   task automatic chk(input int sel, input logic [15:0] exp);
      @(posedge clk);
      #1;
      notes.push_back('{sel, exp});
      ->look;
   endtask : chk
   // one-cycle write strobe; sel high picks the bias register
   task automatic wr(input logic sel, input logic [7:0] v);
      @(posedge clk);
      high_wr <= !sel;
      bias_wr <= sel;
      high_wdata <= v;
      bias_wdata <= v;
      @(posedge clk);
      high_wr <= 1'b0;
      bias_wr <= 1'b0;
   endtask : wr
   // bounded wait for a ramp to finish
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
      for (int i = 0; i < 2000 && ramp_busy !== 1'b0; i++)
      begin
         @(posedge clk);
         #1;
      end
      if (ramp_busy !== 1'b0)
      begin
         mismatches++;
         $display("mismatch ramp_busy expected 0 seen %b", ramp_busy);
      end
   endtask : settle
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done
   // main sequence
   initial
   begin
      lo = 8'($urandom(32'h66fb));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      chk(1, 16'h0000);
      chk(2, 16'h0000);
      wr(1'b1, 8'hff);
      chk(2, 16'h003f);
      chk(3, 16'h003f);
      $display("test bias done");
      // unlocked: offset lands at once, 1024 inverts the output
      wr(1'b0, 8'h04);
      chk(1, 16'h0004);
      settle();
      chk(0, 16'h0400);
      chk(4, 16'h0001);
      $display("test unlocked done");
      // locked: a long way down must be ramped in small steps
      @(posedge clk);
      cfg.locked <= 1'b1;
      watch = 1;
      offset_low <= 8'h20;
      wr(1'b0, 8'h00);
      chk(5, 16'h0001);
      settle();
      chk(0, 16'h0020);
      chk(4, 16'h0000);
      $display("test ramp done");
      // ramping off while locked: negative offset applied directly
      watch = 0;
      @(posedge clk);
      cfg.ramp_disable <= 1'b1;
      offset_low <= lo;
      wr(1'b0, 8'hff);
      settle();
      chk(0, {8'hff, lo});
      $display("test no ramp done");
      // build-out active: programmed offset has no effect
      @(posedge clk);
      cfg.buildout_en <= 1'b1;
      wr(1'b0, 8'h12);
      settle();
      chk(0, 16'h0000);
      chk(1, 16'h0012);
      $display("test buildout done");
      // build-out while locked with ramping on: still no effect, no ramp
      @(posedge clk);
      cfg.ramp_disable <= 1'b0;
      wr(1'b0, 8'h30);
      chk(5, 16'h0000);
      chk(0, 16'h0000);
      $display("test buildout locked done");
      @(posedge clk);
      test_done();
   end
endmodule : testbench
